// ### src/vsw_config_regs.sv
// Purpose: Configuration registers of a four-source video link switch
// Assumes: Serial access strobes and strap pins synchronous to clock
// Notes:   Strap image reloads every cycle until the first serial access
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Input termination select 0 disconnects, 1 connects subject to pulsing
// - Pulse bit 1 opens that channel's termination 100 ms on source change
// - Pulse bits 0-3 B0-3, 4-7 A0-3, 8-11 C3-C0, 12-15 D3-D0
// - Equalizer bit 0 is 6 dB, 1 is 12 dB, same channel mapping
// - Two-bit pre-emphasis 00/01/10/11 gives 0/2/4/6 dB on all outputs
// - Output termination select 0 off, 1 on for all outputs
// - Output current select 0 is 10 mA, 1 is 20 mA
// - Registers load directly from the dedicated strap pins
// - Strap loading holds from reset until first serial register access
// - A strap pin at 3.3 V reads 1, at 0 V reads 0
// - Strap mode: mode bit6 enable pin, bits5-2 zero, bits1-0 source pins
// - Strap mode: auxiliary enable 1, mode zero, source from same pins
// - Strap mode: termination select 1, all pulse bits 0
// - Enable 0 turns channels off into standby, 1 turns them on
// - Source codes 00/01/10/11 route source A/B/C/D
// - Strap mode: one equalizer pin sets every input channel
module vsw_config_regs #(
  parameter int unsigned PULSE_CYCLES = vsw_pkg::PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          rstn,
  // Serial register access
  input  wire vsw_pkg::vsw_addr_t regAddr,
  input  wire logic          regWrEn,
  input  wire logic          regRdEn,
  input  wire vsw_pkg::vsw_byte_t regWrData,
  output var  vsw_pkg::vsw_byte_t regRdData,
  // Strap pins
  input  wire logic          strapHsEnable,
  input  wire vsw_pkg::vsw_src_t strapSourceSelect,
  input  wire logic          strapEqLevel,
  input  wire logic [1:0]    strapPreemphLevel,
  input  wire logic          strapOutputTerm,
  input  wire logic          strapOutputCurrent,
  // High-speed path controls
  output logic               hsEnable,
  output logic               hsStandby,
  output logic [3:0]         hsSwitchMode,
  output vsw_pkg::vsw_src_t  hsSourceSel,
  // Auxiliary path controls
  output logic               auxEnable,
  output logic [3:0]         auxSwitchMode,
  output vsw_pkg::vsw_src_t  auxSourceSel,
  // Input and output analog controls
  output vsw_pkg::vsw_chan_t inputTermConnect,
  output vsw_pkg::vsw_chan_t inputEqHigh,
  output logic [1:0]         outputPreemphLevel,
  output logic               outputTermEnable,
  output logic               outputCurrentSel,
  // Status
  output logic               strapModeActive
);
  import vsw_pkg::*;

  // ****************************************
  // Channel mapping
  // ****************************************
  // Reorders register bits to index source*4+channel, source A first
  // bit to channel map
  function automatic vsw_chan_t chanMap(input vsw_chan_t bits);
    vsw_chan_t m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[0 + i]  = bits[4 + i];
      m[4 + i]  = bits[i];
      m[8 + i]  = bits[11 - i];
      m[12 + i] = bits[15 - i];
    end
    return m;
  endfunction : chanMap

  vsw_byte_t  regFile_r [NUM_REGS];
  vsw_byte_t  regFile_nxt [NUM_REGS];
  vsw_byte_t  strapImg [NUM_REGS];
  vsw_byte_t  rdData_r, rdData_nxt;
  logic       strapMode_r, strapMode_nxt;
  vsw_src_t   prevSrc_r, prevSrc_nxt;
  vsw_chan_t  termConn_r, termConn_nxt;
  vsw_chan_t  pulseBits, eqBits, pulseMask;
  logic       rxTermEn, srcChange, anyAccess;

  vsw_pulse_if pulse ();

  // ****************************************
  // Strap image
  // ****************************************
  // Pins are logic levels here: 3.3 V arrives as 1, 0 V as 0
  // pin levels
  always_comb begin
    strapImg[OFS_HS_MODES] = {1'b0, strapHsEnable, 4'h0, strapSourceSelect};
    strapImg[OFS_AUX_MODES] = {1'b0, 1'b1, 4'h0, strapSourceSelect};
    strapImg[OFS_RX_SETTINGS] = 8'h01;
    strapImg[OFS_TERM_PULSE1] = 8'h00;
    strapImg[OFS_TERM_PULSE2] = 8'h00;
    strapImg[OFS_RX_EQ1] = {8{strapEqLevel}};
    strapImg[OFS_RX_EQ2] = {8{strapEqLevel}};
    strapImg[OFS_TX_SETTINGS] = {4'h0, strapPreemphLevel,
                                 strapOutputTerm, strapOutputCurrent};
  end

  // ****************************************
  // Register file
  // ****************************************
  assign anyAccess = regWrEn || regRdEn;

  always_comb begin
    regFile_nxt   = regFile_r;
    strapMode_nxt = strapMode_r;
    rdData_nxt    = rdData_r;
    if (strapMode_r) begin
      regFile_nxt = strapImg;
    end
    if (anyAccess) begin
      strapMode_nxt = 1'b0;
    end
    if (regWrEn) begin
      regFile_nxt[regAddr] = regWrData & REG_MASK[regAddr];
    end
    if (regRdEn) begin
      rdData_nxt = regFile_r[regAddr] & REG_MASK[regAddr];
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      regFile_r   <= REG_RESET;
      strapMode_r <= 1'b1;
      rdData_r    <= 8'h00;
    end else begin
      regFile_r   <= regFile_nxt;
      strapMode_r <= strapMode_nxt;
      rdData_r    <= rdData_nxt;
    end
  end

  // ****************************************
  // Field decode
  // ****************************************
  assign pulseBits = {regFile_r[OFS_TERM_PULSE2], regFile_r[OFS_TERM_PULSE1]};
  assign eqBits    = {regFile_r[OFS_RX_EQ2], regFile_r[OFS_RX_EQ1]};
  assign pulseMask = chanMap(pulseBits);
  assign rxTermEn  = regFile_r[OFS_RX_SETTINGS][RX_TERM_BIT];

  assign hsEnable     = regFile_r[OFS_HS_MODES][MODE_EN_BIT];
  assign hsStandby    = !regFile_r[OFS_HS_MODES][MODE_EN_BIT];
  assign hsSwitchMode = regFile_r[OFS_HS_MODES][MODE_SEL_MSB:MODE_SEL_LSB];
  assign hsSourceSel  = regFile_r[OFS_HS_MODES][SRC_SEL_MSB:SRC_SEL_LSB];
  assign auxEnable     = regFile_r[OFS_AUX_MODES][MODE_EN_BIT];
  assign auxSwitchMode = regFile_r[OFS_AUX_MODES][MODE_SEL_MSB:MODE_SEL_LSB];
  assign auxSourceSel  = regFile_r[OFS_AUX_MODES][SRC_SEL_MSB:SRC_SEL_LSB];
  assign inputEqHigh = chanMap(eqBits);
  assign outputPreemphLevel = regFile_r[OFS_TX_SETTINGS][OUTPUT_PREEMPH_LEVEL_MSB:OUTPUT_PREEMPH_LEVEL_LSB];
  assign outputTermEnable = regFile_r[OFS_TX_SETTINGS][TX_OTO_BIT];
  assign outputCurrentSel = regFile_r[OFS_TX_SETTINGS][OUTPUT_CURRENT_SEL_BIT];
  assign strapModeActive  = strapMode_r;
  assign regRdData        = rdData_r;

  // ****************************************
  // Termination pulsing
  // ****************************************
  assign srcChange   = hsSourceSel != prevSrc_r;
  assign pulse.start = srcChange && (pulseBits != '0);

  always_comb begin
    prevSrc_nxt = hsSourceSel;
    termConn_nxt = {16{rxTermEn}} & ~({16{pulse.active}} & pulseMask);
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      prevSrc_r  <= 2'h0;
      termConn_r <= 16'h0000;
    end else begin
      prevSrc_r  <= prevSrc_nxt;
      termConn_r <= termConn_nxt;
    end
  end

  assign inputTermConnect = termConn_r;

  vsw_term_pulse #(
    .PULSE_CYCLES (PULSE_CYCLES)
  ) u_term_pulse (
    .clock (clock),
    .rstn  (rstn),
    .pulse (pulse)
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  strap_exit_a : assert property (anyAccess |=> !strapModeActive)
    else $error("strap mode survived a serial access");

  strap_closed_a : assert property (
    !strapModeActive |=> !strapModeActive)
    else $error("strap mode reopened without reset");

  strap_hs_image_a : assert property (
    strapMode_r && !anyAccess |=> hsEnable == $past(strapHsEnable)
      && hsSwitchMode == 4'h0 && hsSourceSel == $past(strapSourceSelect))
    else $error("high-speed strap image wrong");

  strap_aux_image_a : assert property (
    strapMode_r && !anyAccess |=> auxEnable && auxSwitchMode == 4'h0
      && auxSourceSel == $past(strapSourceSelect))
    else $error("auxiliary strap image wrong");

  strap_term_a : assert property (
    strapMode_r && !anyAccess |=> rxTermEn && pulseBits == 16'h0000)
    else $error("strap termination image wrong");

  strap_eq_a : assert property (
    strapMode_r && !anyAccess |=> inputEqHigh == {16{$past(strapEqLevel)}})
    else $error("strap equalizer not applied to all channels");

  strap_tx_a : assert property (
    strapMode_r && !anyAccess
      |=> outputPreemphLevel == $past(strapPreemphLevel)
      && outputTermEnable == $past(strapOutputTerm)
      && outputCurrentSel == $past(strapOutputCurrent))
    else $error("transmitter strap image wrong");

  serial_tx_a : assert property (
    regWrEn && regAddr == OFS_TX_SETTINGS
      |=> {outputPreemphLevel, outputTermEnable, outputCurrentSel}
      == $past(regWrData[3:0]))
    else $error("serial transmitter write not kept");

  term_off_a : assert property (
    !rxTermEn |=> inputTermConnect == 16'h0000)
    else $error("termination connected while deselected");

  pulse_open_a : assert property (
    pulse.start && rxTermEn && pulseBits == 16'h0100
      ##1 rxTermEn && pulseBits == 16'h0100
      |=> inputTermConnect == 16'hF7FF)
    else $error("pulsed channel C3 not disconnected");

  term_idle_a : assert property (
    !pulse.active && rxTermEn |=> inputTermConnect == 16'hFFFF)
    else $error("termination open outside a pulse window");

  eq_map_a : assert property (
    inputEqHigh[11] == eqBits[8] && inputEqHigh[4] == eqBits[0]
      && inputEqHigh[0] == eqBits[4] && inputEqHigh[12] == eqBits[15])
    else $error("equalizer channel mapping wrong");

  serial_hold_a : assert property (
    !strapModeActive && !regWrEn |=> $stable(hsSourceSel)
      && $stable(inputEqHigh) && $stable(outputPreemphLevel))
    else $error("register changed without a serial write");

  switch_pulse_a : assert property (
    hsSourceSel != $past(hsSourceSel) && pulseBits != 16'h0000 && rxTermEn
      ##1 rxTermEn && pulseBits != 16'h0000
      |=> inputTermConnect != 16'hFFFF)
    else $error("source change did not open a pulsed termination");

  pulse_map_a : assert property (
    $past(pulse.active) && $past(rxTermEn) && $stable(pulseBits)
      |-> inputTermConnect[3] == !pulseBits[7]
      && inputTermConnect[7] == !pulseBits[3]
      && inputTermConnect[8] == !pulseBits[11]
      && inputTermConnect[15] == !pulseBits[12])
    else $error("pulsed termination channel mapping wrong");

  read_mask_a : assert property (
    $past(regRdEn) && $past(regAddr) == OFS_TX_SETTINGS
      |-> regRdData[7:4] == 4'h0)
    else $error("unused transmitter bits read back set");

  first_write_c : cover property (strapMode_r && regWrEn);
  pulse_start_c : cover property (pulse.start);
  silent_switch_c : cover property (srcChange && pulseBits == 16'h0000);
  strap_load_c : cover property (strapMode_r && strapHsEnable ##1 hsEnable);
  term_gated_c : cover property (pulse.start && !rxTermEn);

endmodule : vsw_config_regs

`default_nettype wire

// ### common/vsw_pkg.sv
// Purpose: Shared constants and types for the video switch config block
// Assumes: 40 MHz clock, 8-bit registers on a 3-bit address
// Notes:   Offsets and masks index the register array directly
`default_nettype none

package vsw_pkg;

  // ****************************************
  // Types
  // ****************************************
  typedef logic [7:0] vsw_byte_t;
  typedef logic [2:0] vsw_addr_t;
  typedef logic [1:0] vsw_src_t;
  typedef logic [15:0] vsw_chan_t;
  typedef logic [21:0] vsw_count_t;

  typedef enum logic {
    PS_IDLE = 1'b0,
    PS_HOLD = 1'b1
  } vsw_pulse_state_e;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam int unsigned NUM_REGS = 8;
  localparam vsw_addr_t OFS_HS_MODES    = 3'h0;
  localparam vsw_addr_t OFS_AUX_MODES   = 3'h1;
  localparam vsw_addr_t OFS_RX_SETTINGS = 3'h2;
  localparam vsw_addr_t OFS_TERM_PULSE1 = 3'h3;
  localparam vsw_addr_t OFS_TERM_PULSE2 = 3'h4;
  localparam vsw_addr_t OFS_RX_EQ1      = 3'h5;
  localparam vsw_addr_t OFS_RX_EQ2      = 3'h6;
  localparam vsw_addr_t OFS_TX_SETTINGS = 3'h7;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned MODE_EN_BIT  = 6;
  localparam int unsigned MODE_SEL_LSB = 2;
  localparam int unsigned MODE_SEL_MSB = 5;
  localparam int unsigned SRC_SEL_LSB  = 0;
  localparam int unsigned SRC_SEL_MSB  = 1;
  localparam int unsigned RX_TERM_BIT  = 0;
  localparam int unsigned OUTPUT_PREEMPH_LEVEL_LSB    = 2;
  localparam int unsigned OUTPUT_PREEMPH_LEVEL_MSB    = 3;
  localparam int unsigned TX_OTO_BIT   = 1;
  localparam int unsigned OUTPUT_CURRENT_SEL_BIT   = 0;

  // ****************************************
  // Writable masks and reset values
  // ****************************************
  localparam vsw_byte_t REG_MASK [NUM_REGS] = '{
    8'h7F, 8'h7F, 8'h01, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F};
  localparam vsw_byte_t REG_RESET [NUM_REGS] = '{
    8'h00, 8'h40, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned PULSE_MS     = 100;
  localparam int unsigned PULSE_CYCLES = PULSE_MS * (CLK_HZ / 1000);

endpackage : vsw_pkg

`default_nettype wire

// ### common/vsw_pulse_if.sv
// Purpose: Carries the termination pulse trigger and its active window
// Assumes: Both ends share one clock
// Notes:   ctrl starts the window, timer reports it
`timescale 1ns/1ps
`default_nettype none

interface vsw_pulse_if;
  logic start;
  logic active;
  modport ctrl  (output start, input active);
  modport timer (input start, output active);
endinterface : vsw_pulse_if

`default_nettype wire

// ### src/vsw_term_pulse.sv
// Purpose: Times the input termination disconnect window
// Assumes: start is a one-cycle pulse, synchronous to clock
// Notes:   A start during the window restarts it
`timescale 1ns/1ps
`default_nettype none

module vsw_term_pulse #(
  parameter int unsigned PULSE_CYCLES = vsw_pkg::PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic  clock,
  input  wire logic  rstn,
  // Pulse trigger and window
  vsw_pulse_if.timer pulse
);
  import vsw_pkg::*;

  localparam vsw_count_t LAST_COUNT = vsw_count_t'(PULSE_CYCLES - 1);

  vsw_pulse_state_e state_r, state_nxt;
  vsw_count_t       count_r, count_nxt;

  // ****************************************
  // Window counter
  // ****************************************
  // window length
  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    if (pulse.start) begin
      state_nxt = PS_HOLD;
      count_nxt = LAST_COUNT;
    end else begin
      unique case (state_r)
        PS_IDLE: count_nxt = count_r;
        PS_HOLD: begin
          if (count_r == '0) begin
            state_nxt = PS_IDLE;
          end else begin
            count_nxt = count_r - 22'h000001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_r <= PS_IDLE;
      count_r <= '0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
    end
  end

  assign pulse.active = (state_r == PS_HOLD);

  // ****************************************
  // Checks
  // ****************************************
  pulse_load_a : assert property (@(posedge clock) disable iff (!rstn)
    pulse.start |=> pulse.active && count_r == LAST_COUNT)
    else $error("pulse window did not load full length");

  pulse_end_a : assert property (@(posedge clock) disable iff (!rstn)
    pulse.active && count_r == '0 && !pulse.start |=> !pulse.active)
    else $error("pulse window overran its length");

endmodule : vsw_term_pulse

`default_nettype wire

// ### verification/vsw_strap_board.sv
// Purpose: Board strap model for the video switch config block
// Assumes: Each jumper ties its pin to 3.3 V (1) or 0 V (0)
// Notes:   Jumper bit order matches the bench strap image
`timescale 1ns/1ps
`default_nettype none

module vsw_strap_board (
  // Jumper settings
  input  wire logic [7:0]   jumpers,
  // Strap pins
  output logic              hsEnPin,
  output vsw_pkg::vsw_src_t srcPins,
  output logic              eqPin,
  output logic [1:0]        preemphPins,
  output logic              otermPin,
  output logic              ocurPin
);
  import vsw_pkg::*;
  // ****************************************
  // Pin levels
  // ****************************************
  // fitted jumper reads 1
  assign hsEnPin     = jumpers[0];
  assign srcPins     = jumpers[2:1];
  assign eqPin       = jumpers[3];
  assign preemphPins = jumpers[5:4];
  assign otermPin    = jumpers[6];
  assign ocurPin     = jumpers[7];
endmodule : vsw_strap_board

`default_nettype wire

// ### verification/video_switch_phy_config_regs_bench.sv
// Purpose: Self-checking bench for the video switch config registers
// Assumes: Short pulse window of 20 cycles, 25 ns clock
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none

module video_switch_phy_config_regs_bench;
  import vsw_pkg::*;
  localparam int unsigned PULSE = 20;
  logic       clock;
  logic       rstn;
  vsw_addr_t  regAddr;
  logic       regWrEn;
  logic       regRdEn;
  vsw_byte_t  regWrData;
  vsw_byte_t  regRdData;
  logic [7:0] jumpers;
  logic       sHs, sEq, sOt, sOc;
  vsw_src_t   sSrc;
  logic [1:0] sPe;
  logic       hsEnable, hsStandby, auxEnable, strapModeActive;
  logic [3:0] hsSwitchMode, auxSwitchMode;
  vsw_src_t   hsSourceSel, auxSourceSel;
  vsw_chan_t  inputTermConnect, inputEqHigh;
  logic [1:0] outputPreemphLevel;
  logic       outputTermEnable, outputCurrentSel;
  int         nErrors, compares, cycles;
  vsw_byte_t  rd;
  vsw_src_t   curSrc;
  logic [15:0] pat;
  logic [7:0] tbl [4] = '{8'h00, 8'hFF, 8'h5B, 8'hA5};

  vsw_strap_board board (.jumpers(jumpers), .hsEnPin(sHs), .srcPins(sSrc),
    .eqPin(sEq), .preemphPins(sPe), .otermPin(sOt), .ocurPin(sOc));

  vsw_config_regs #(.PULSE_CYCLES(PULSE)) dut (
    .clock(clock), .rstn(rstn), .regAddr(regAddr), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
    .strapHsEnable(sHs), .strapSourceSelect(sSrc), .strapEqLevel(sEq),
    .strapPreemphLevel(sPe), .strapOutputTerm(sOt),
    .strapOutputCurrent(sOc), .hsEnable(hsEnable), .hsStandby(hsStandby),
    .hsSwitchMode(hsSwitchMode), .hsSourceSel(hsSourceSel),
    .auxEnable(auxEnable), .auxSwitchMode(auxSwitchMode),
    .auxSourceSel(auxSourceSel), .inputTermConnect(inputTermConnect),
    .inputEqHigh(inputEqHigh), .outputPreemphLevel(outputPreemphLevel),
    .outputTermEnable(outputTermEnable),
    .outputCurrentSel(outputCurrentSel), .strapModeActive(strapModeActive));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic testDone();
    $display("Checks %0d, mismatches %0d", compares, nErrors);
    if (nErrors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : testDone

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      nErrors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic waitCycles(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : waitCycles

  task automatic regWrite(input vsw_addr_t a, input vsw_byte_t d);
    @(posedge clock);
    #1;
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge clock);
    #1;
    regWrEn = 1'b0;
  endtask : regWrite

  task automatic regRead(input vsw_addr_t a, output vsw_byte_t d);
    @(posedge clock);
    #1;
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge clock);
    #1;
    regRdEn = 1'b0;
    d = regRdData;
  endtask : regRead

  // Channel vector index is source*4 + channel
  function automatic vsw_chan_t chanMap(input logic [15:0] p);
    vsw_chan_t c;
    for (int k = 0; k < 4; k++) begin
      c[4+k]  = p[k];
      c[k]    = p[4+k];
      c[11-k] = p[8+k];
      c[15-k] = p[12+k];
    end
    return c;
  endfunction : chanMap

  task automatic checkStraps(input logic [7:0] j);
    check(16'(hsEnable), 16'(j[0]));
    check(16'(hsStandby), 16'(!j[0]));
    check(16'(hsSwitchMode), 16'h0);
    check(16'(hsSourceSel), 16'(j[2:1]));
    check(16'(auxEnable), 16'h1);
    check(16'(auxSwitchMode), 16'h0);
    check(16'(auxSourceSel), 16'(j[2:1]));
    check(inputTermConnect, 16'hFFFF);
    check(inputEqHigh, {16{j[3]}});
    check(16'(outputPreemphLevel), 16'(j[5:4]));
    check(16'(outputTermEnable), 16'(j[6]));
    check(16'(outputCurrentSel), 16'(j[7]));
    check(16'(strapModeActive), 16'h1);
  endtask : checkStraps

  // ****************************************
  // Clock, timeout and sequence
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      nErrors++;
      testDone();
    end
  end

  initial begin
    rstn = 1'b0;
    regAddr = '0;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regWrData = '0;
    jumpers = 8'h00;
    repeat (6) @(posedge clock);
    #1;
    rstn = 1'b1;
    foreach (tbl[i]) begin
      jumpers = tbl[i];
      waitCycles(2);
      checkStraps(tbl[i]);
    end
    regRead(OFS_RX_SETTINGS, rd);
    check(16'(rd), 16'h01);
    check(16'(strapModeActive), 16'h0);
    jumpers = 8'h5A;
    waitCycles(2);
    check(16'(hsSourceSel), 16'h2);
    check(16'(outputPreemphLevel), 16'h2);
    check(16'(hsEnable), 16'h1);
    for (int p = 0; p < 4; p++) begin
      regWrite(OFS_TX_SETTINGS, {4'h0, 2'(p), p[0], ~p[0]});
      check(16'(outputPreemphLevel), 16'(p[1:0]));
      check(16'(outputTermEnable), 16'(p[0]));
      check(16'(outputCurrentSel), 16'(!p[0]));
    end
    regWrite(OFS_TX_SETTINGS, 8'hFF);
    regRead(OFS_TX_SETTINGS, rd);
    check(16'(rd), 16'h0F);
    regWrite(OFS_RX_EQ1, 8'hA5);
    regWrite(OFS_RX_EQ2, 8'h3C);
    check(inputEqHigh, chanMap(16'h3CA5));
    for (int s = 0; s < 4; s++) begin
      regWrite(OFS_HS_MODES, {6'h10, 2'(s)});
      waitCycles(3);
      check(16'(hsSourceSel), 16'(s));
      check(16'(hsStandby), 16'h0);
      check(inputTermConnect, 16'hFFFF);
    end
    regWrite(OFS_HS_MODES, 8'h03);
    check(16'(hsEnable), 16'h0);
    check(16'(hsStandby), 16'h1);
    curSrc = 2'h3;
    // one pulse bit at a time
    for (int i = 0; i < 16; i++) begin
      pat = 16'h1 << i;
      regWrite(OFS_TERM_PULSE1, pat[7:0]);
      regWrite(OFS_TERM_PULSE2, pat[15:8]);
      curSrc = curSrc + 2'h1;
      regWrite(OFS_HS_MODES, {6'h10, curSrc});
      waitCycles(4);
      check(inputTermConnect, ~chanMap(pat));
      waitCycles(PULSE + 4);
      check(inputTermConnect, 16'hFFFF);
    end
    regWrite(OFS_RX_SETTINGS, 8'hFE);
    waitCycles(1);
    check(inputTermConnect, 16'h0000);
    regWrite(OFS_HS_MODES, 8'h40);
    waitCycles(4);
    check(inputTermConnect, 16'h0000);
    regWrite(OFS_RX_SETTINGS, 8'hFF);
    regRead(OFS_RX_SETTINGS, rd);
    check(16'(rd), 16'h01);
    // a fresh reset reopens straps, a write closes them
    rstn = 1'b0;
    jumpers = 8'hFF;
    waitCycles(6);
    rstn = 1'b1;
    regWrite(OFS_TX_SETTINGS, 8'h04);
    check(16'(strapModeActive), 16'h0);
    check(16'(outputPreemphLevel), 16'h1);
    check(16'(outputTermEnable), 16'h0);
    check(16'(hsSourceSel), 16'h3);
    testDone();
  end
endmodule : video_switch_phy_config_regs_bench

`default_nettype wire
